// ### common/srs_pkg.sv
/*
 Shared constants for the standby release and reset sequencer: APB
 offsets, field positions, reset values, settling times and states.
 Assumes a single 40 MHz system clock that also stands for the main
 oscillator period when settling waits are counted.
*/
package srs_pkg;

	// Clock and settling times
	localparam int SRS_CLK_PERIOD_NS   = 25;
	localparam int SRS_RESET_WAIT_NS   = 31300000;
	localparam int SRS_RESET_WAIT_CYC  = SRS_RESET_WAIT_NS / SRS_CLK_PERIOD_NS;
	localparam int SRS_WAIT_EXP_A      = 20;
	localparam int SRS_WAIT_EXP_B      = 17;
	localparam int SRS_WAIT_EXP_C      = 15;
	localparam int SRS_WAIT_EXP_D      = 13;
	localparam int SRS_WAIT_A_CYC      = 2 ** SRS_WAIT_EXP_A;
	localparam int SRS_WAIT_B_CYC      = 2 ** SRS_WAIT_EXP_B;
	localparam int SRS_WAIT_C_CYC      = 2 ** SRS_WAIT_EXP_C;
	localparam int SRS_WAIT_D_CYC      = 2 ** SRS_WAIT_EXP_D;
	localparam int SRS_VECTOR_DELAY    = 2;

	// Wait select codes, bits [2:0] of interval_timer_mode
	localparam logic [2:0] SRS_CODE_A = 3'h0;
	localparam logic [2:0] SRS_CODE_B = 3'h3;
	localparam logic [2:0] SRS_CODE_C = 3'h5;
	localparam logic [2:0] SRS_CODE_D = 3'h7;

	// Register byte offsets
	localparam logic [11:0] SRS_OFS_PCC  = 12'h000;
	localparam logic [11:0] SRS_OFS_ITM  = 12'h004;
	localparam logic [11:0] SRS_OFS_WTM  = 12'h008;
	localparam logic [11:0] SRS_OFS_BANK = 12'h00c;
	localparam logic [11:0] SRS_OFS_PSW  = 12'h010;
	localparam logic [11:0] SRS_OFS_STAT = 12'h014;

	// Field positions
	localparam int SRS_PCC_STOP_BIT = 3;
	localparam int SRS_PCC_HALT_BIT = 2;
	localparam int SRS_ROM_RBE_BIT  = 6;
	localparam int SRS_ROM_MBE_BIT  = 7;
	localparam int SRS_PC_HI_W      = 6;
	localparam int SRS_RBS_LSB      = 4;

	// Values after reset
	localparam logic [1:0] SRS_PCC_RST  = 2'h0;
	localparam logic [3:0] SRS_ITM_RST  = 4'h0;
	localparam logic [7:0] SRS_WTM_RST  = 8'h00;
	localparam logic [3:0] SRS_MBS_RST  = 4'h0;
	localparam logic [1:0] SRS_RBS_RST  = 2'h0;
	localparam logic [1:0] SRS_NEST_RST = 2'h0;
	localparam logic [2:0] SRS_SKIP_RST = 3'h0;

	// Sequencer states
	typedef enum logic [2:0] {
		SRS_RUN       = 3'b000,
		SRS_HALT      = 3'b001,
		SRS_STOP      = 3'b010,
		SRS_OSC_START = 3'b011,
		SRS_SETTLE    = 3'b100,
		SRS_RST_HOLD  = 3'b101
	} srs_state_e;

endpackage

// ### logic/srs_standby_seq.sv
/*
 Standby release and reset sequencer: stop/halt entry, release by
 reset pin or enabled interrupt, oscillator settling wait, post-release
 resume or vectored interrupt, and reset-state loading, with an APB
 slave for its registers.
 Assumes irq and rom inputs come from logic on the same clock, while
 the reset pin and oscillator-running level come from outside.
*/
`timescale 1ns/1ps
module srs_standby_seq
	import srs_pkg::*;
#(
	parameter int NUM_IRQ    = 8,
	parameter int WATCH_IDX  = 0,
	parameter int EXT2_IDX   = 1,
	parameter int CNT_W      = 22,
	parameter int WAIT_A_CYC = SRS_WAIT_A_CYC,
	parameter int WAIT_B_CYC = SRS_WAIT_B_CYC,
	parameter int WAIT_C_CYC = SRS_WAIT_C_CYC,
	parameter int WAIT_D_CYC = SRS_WAIT_D_CYC,
	parameter int RESET_WAIT = SRS_RESET_WAIT_CYC
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               arst_n,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Pins
	input  wire logic               resetPin_n,
	input  wire logic               oscRunning,
	output logic                    oscEnable,
	// Interrupt sources
	input  wire logic [NUM_IRQ-1:0] irqReq,
	input  wire logic [NUM_IRQ-1:0] irqEn,
	input  wire logic               global_irq_enable,
	// CPU core
	input  wire logic [7:0]         romByte0,
	input  wire logic [7:0]         romByte1,
	input  wire logic               instrDone,
	output logic                    cpuClockEnable,
	output logic                    resumeNext,
	output logic                    takeVector,
	output logic                    pcLoad,
	output logic      [13:0]        program_counter,
	output logic                    reg_bank_enable,
	output logic                    mem_bank_enable,
	output logic                    regsRetained,
	output logic      [NUM_IRQ-1:0] wakeCause,
	// Reset-cleared state
	output logic      [3:0]         interval_timer_mode,
	output logic      [7:0]         watch_timer_mode,
	output logic      [3:0]         mem_bank_select,
	output logic      [1:0]         reg_bank_select,
	output logic      [1:0]         nestStatus,
	output logic      [2:0]         skipFlags
);

	srs_state_e       state;
	logic             rstPinSync_n;
	logic             oscSync;
	logic             rstPath;
	logic             timerLoad;
	logic [CNT_W-1:0] timerVal;
	logic             timerDone;
	logic [1:0]       pccClock;
	logic [1:0]       vecCount;
	logic             vecArmed;
	logic             wake;
	logic             apbWrite;
	logic             apbSetup;
	logic             rstClear;
	logic             settleDone;
	logic             wakeVectorable;
	logic [NUM_IRQ-1:0] noVecMask;

	// Reset pin and oscillator status come from outside
	srs_sync #(.RST_VAL(1'b0)) u_rst_sync (
		.clock   (clock),
		.arst_n  (arst_n),
		.rawIn   (resetPin_n),
		.syncOut (rstPinSync_n)
	);

	srs_sync #(.RST_VAL(1'b0)) u_osc_sync (
		.clock   (clock),
		.arst_n  (arst_n),
		.rawIn   (oscRunning),
		.syncOut (oscSync)
	);

	srs_wait_timer #(.CNT_W(CNT_W)) u_wait (
		.clock   (clock),
		.arst_n  (arst_n),
		.load    (timerLoad),
		.loadVal (timerVal),
		.expired (timerDone)
	);

	// Wait select decode; prohibited codes fall back to the longest
	function automatic logic [CNT_W-1:0] waitFor(input logic [3:0] mode);
		logic [CNT_W-1:0] n;
		n = CNT_W'(WAIT_A_CYC);
		case (mode[2:0]) // bit 3 ignored
			SRS_CODE_A: n = CNT_W'(WAIT_A_CYC);
			SRS_CODE_B: n = CNT_W'(WAIT_B_CYC);
			SRS_CODE_C: n = CNT_W'(WAIT_C_CYC);
			SRS_CODE_D: n = CNT_W'(WAIT_D_CYC);
			default:    n = CNT_W'(WAIT_A_CYC);
		endcase
		return n;
	endfunction

	// Common decodes
	assign wake       = |(irqReq & irqEn);
	assign apbSetup   = psel && !penable;
	assign apbWrite   = psel && penable && pready && pwrite && !pslverr;
	assign rstClear   = (state == SRS_RST_HOLD);
	assign settleDone = (state == SRS_SETTLE) && timerDone;

	// Sources that never vector on release
	always_comb begin
		noVecMask = '0;
		noVecMask[WATCH_IDX] = 1'b1;
		noVecMask[EXT2_IDX]  = 1'b1;
	end
	assign wakeVectorable = |(wakeCause & ~noVecMask);

	// Timer load: count starts on entering the settle state
	always_comb begin
		timerLoad = 1'b0;
		timerVal  = '0;
		if (state == SRS_OSC_START && oscSync) begin
			timerLoad = 1'b1;
			timerVal  = rstPath ? CNT_W'(RESET_WAIT)
			                    : waitFor(interval_timer_mode);
		end else if (state == SRS_RST_HOLD && rstPinSync_n && oscSync) begin
			timerLoad = 1'b1;
			timerVal  = CNT_W'(RESET_WAIT);
		end else if (state == SRS_RUN && apbWrite
		             && paddr == SRS_OFS_PCC
		             && pwdata[SRS_PCC_STOP_BIT] && wake) begin
			timerLoad = 1'b1;
			timerVal  = waitFor(interval_timer_mode);
		end
	end

	// Main sequencer
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state   <= SRS_RST_HOLD;
			rstPath <= 1'b1;
		end else if (!rstPinSync_n) begin
			state   <= SRS_RST_HOLD;
			rstPath <= 1'b1;
		end else begin
			case (state)
				SRS_RUN: begin
					if (apbWrite && paddr == SRS_OFS_PCC) begin
						if (pwdata[SRS_PCC_STOP_BIT]) begin
							// Oscillator never stops if already woken
							state <= wake ? SRS_SETTLE : SRS_STOP;
						end else if (pwdata[SRS_PCC_HALT_BIT]) begin
							state <= SRS_HALT;
						end
					end
					rstPath <= 1'b0;
				end
				SRS_HALT: begin
					if (wake) begin
						state <= SRS_RUN;
					end
				end
				SRS_STOP: begin
					// Stale synced running level must drop first
					if (wake && !oscSync) begin
						state <= SRS_OSC_START;
					end
				end
				SRS_OSC_START: begin
					if (oscSync) begin
						state <= SRS_SETTLE;
					end
				end
				SRS_SETTLE: begin
					if (timerDone) begin
						state <= SRS_RUN;
					end
				end
				SRS_RST_HOLD: begin
					state <= oscSync ? SRS_SETTLE : SRS_OSC_START;
				end
				default: state <= SRS_RST_HOLD;
			endcase
		end
	end

	// Oscillator and CPU clock gating
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			oscEnable      <= 1'b1;
			cpuClockEnable <= 1'b0;
		end else begin
			oscEnable      <= !(state == SRS_STOP && rstPinSync_n
			                    && !(wake && !oscSync));
			cpuClockEnable <= rstPinSync_n
			                  && (state == SRS_RUN && !timerLoad
			                      && !(apbWrite && paddr == SRS_OFS_PCC
			                           && pwdata[SRS_PCC_HALT_BIT])
			                      || state == SRS_HALT && wake
			                      || settleDone);
		end
	end

	// Latch the waking requests for the release decision
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wakeCause <= '0;
		end else if (rstClear) begin
			wakeCause <= '0;
		end else if ((state == SRS_HALT || state == SRS_STOP) && wake) begin
			wakeCause <= irqReq & irqEn;
		end else if (state == SRS_RUN && timerLoad) begin
			wakeCause <= irqReq & irqEn;
		end
	end

	// Release actions: resume pulse, and vector after two instructions.
	// No request flag is cleared here, so a masked cause stays set.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			resumeNext <= 1'b0;
			takeVector <= 1'b0;
			vecArmed   <= 1'b0;
			vecCount   <= 2'h0;
		end else begin
			resumeNext <= 1'b0;
			takeVector <= 1'b0;
			if (rstClear) begin
				vecArmed <= 1'b0;
			end else if ((state == SRS_HALT && wake
			              || settleDone && !rstPath)) begin
				resumeNext <= 1'b1;
				// Cause latched this cycle when leaving halt
				if (global_irq_enable
				    && (state == SRS_HALT
				        ? |(irqReq & irqEn & ~noVecMask)
				        : wakeVectorable)) begin
					vecArmed <= 1'b1;
					vecCount <= 2'(SRS_VECTOR_DELAY);
				end
			end else if (vecArmed && instrDone) begin
				if (vecCount == 2'h1) begin
					vecArmed   <= 1'b0;
					takeVector <= 1'b1;
				end
				vecCount <= vecCount - 2'h1;
			end
		end
	end

	// Reset completion loads vector address and bank enables
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pcLoad          <= 1'b0;
			program_counter <= 14'h0000;
			reg_bank_enable <= 1'b0;
			mem_bank_enable <= 1'b0;
		end else begin
			pcLoad <= settleDone && rstPath && rstPinSync_n;
			if (settleDone && rstPath) begin
				program_counter <= {romByte0[SRS_PC_HI_W-1:0], romByte1};
				reg_bank_enable <= romByte0[SRS_ROM_RBE_BIT];
				mem_bank_enable <= romByte0[SRS_ROM_MBE_BIT];
			end
		end
	end

	// Register retention depends on the state the reset met
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			regsRetained <= 1'b0;
		end else if (!rstPinSync_n && state != SRS_RST_HOLD) begin
			regsRetained <= (state == SRS_HALT || state == SRS_STOP
			                 || state == SRS_OSC_START);
		end
	end

	// Software registers; the reset pin clears them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pccClock            <= SRS_PCC_RST;
			interval_timer_mode <= SRS_ITM_RST;
			watch_timer_mode    <= SRS_WTM_RST;
			mem_bank_select     <= SRS_MBS_RST;
			reg_bank_select     <= SRS_RBS_RST;
			nestStatus          <= SRS_NEST_RST;
			skipFlags           <= SRS_SKIP_RST;
		end else if (rstClear) begin
			pccClock            <= SRS_PCC_RST;
			interval_timer_mode <= SRS_ITM_RST;
			watch_timer_mode    <= SRS_WTM_RST;
			mem_bank_select     <= SRS_MBS_RST;
			reg_bank_select     <= SRS_RBS_RST;
			nestStatus          <= SRS_NEST_RST;
			skipFlags           <= SRS_SKIP_RST;
		end else if (apbWrite) begin
			case (paddr)
				SRS_OFS_PCC:  pccClock <= pwdata[1:0];
				SRS_OFS_ITM:  interval_timer_mode <= pwdata[3:0];
				SRS_OFS_WTM:  watch_timer_mode <= pwdata[7:0];
				SRS_OFS_BANK: begin
					mem_bank_select <= pwdata[3:0];
					reg_bank_select <= pwdata[SRS_RBS_LSB+1:SRS_RBS_LSB];
				end
				SRS_OFS_PSW: begin
					nestStatus <= pwdata[1:0];
					skipFlags  <= pwdata[4:2];
				end
				default: ;
			endcase
		end
	end

	// APB answer one cycle after setup; data sampled at setup
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apbSetup;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (apbSetup) begin
				case (paddr)
					SRS_OFS_PCC: prdata <= {28'h0,
					                        state == SRS_STOP,
					                        state == SRS_HALT, pccClock};
					SRS_OFS_ITM:  prdata <= {28'h0, interval_timer_mode};
					SRS_OFS_WTM:  prdata <= {24'h0, watch_timer_mode};
					SRS_OFS_BANK: prdata <= {26'h0, reg_bank_select,
					                         mem_bank_select};
					SRS_OFS_PSW:  prdata <= {27'h0, skipFlags, nestStatus};
					SRS_OFS_STAT: prdata <= {16'h0, 8'(wakeCause),
					                         3'h0, regsRetained,
					                         rstPath, state};
					default:      pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

// ### logic/srs_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes the input is asynchronous to clock; the output changes only
 when the second and third stages agree.
*/
`timescale 1ns/1ps
module srs_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// Raw and filtered level
	input  wire logic rawIn,
	output logic      syncOut
);

	logic stage1;
	logic stage2;
	logic stage3;

	// Shift chain; stage1 feeds stage2 only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
		end else begin
			stage1 <= rawIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Filtered output follows once two stages agree
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			syncOut <= RST_VAL;
		end else if (stage2 == stage3) begin
			syncOut <= stage3;
		end
	end

endmodule

// ### logic/srs_wait_timer.sv
/*
 Down counter for settling waits.
 Assumes the owner pulses load with the cycle count; expired is high
 once that many cycles have passed and stays high until the next load.
*/
`timescale 1ns/1ps
module srs_wait_timer #(
	parameter int CNT_W = 22
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             arst_n,
	// Control
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] loadVal,
	// Status
	output logic                  expired
);

	logic [CNT_W-1:0] count;

	// Load wins over counting
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else if (load) begin
			count <= loadVal;
		end else if (count != '0) begin
			count <= count - CNT_W'(1);
		end
	end

	assign expired = (count == '0) && !load;

endmodule

// ### tb/srs_cpu_model.sv
/*
 Far-side model: oscillator with start-up delay, program memory bytes
 and a CPU that retires instructions while clocked.
 Assumes the sequencer clock; slow stretches the instruction time.
*/
`timescale 1ns/1ps
module srs_cpu_model #(
	parameter logic [7:0] ROM0      = 8'hb5,
	parameter logic [7:0] ROM1      = 8'h3c,
	parameter int         OSC_START = 4
) (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  arst_n,
	// From the sequencer; slow from the bench
	input  wire logic  oscEnable,
	input  wire logic  cpuClockEnable,
	input  wire logic  slow,
	// To the sequencer
	output logic       oscRunning,
	output logic       instrDone,
	output logic [7:0] romByte0,
	output logic [7:0] romByte1
);
	int oscCnt;
	int instCnt;
	int lastCnt;

	assign romByte0 = ROM0;
	assign romByte1 = ROM1;
	assign lastCnt = slow ? 4 : 1;

	// Oscillator dies at once but needs time to start again
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n || !oscEnable) begin
			oscCnt     <= 0;
			oscRunning <= 1'b0;
		end else begin
			oscCnt     <= (oscCnt < OSC_START) ? oscCnt + 1 : oscCnt;
			oscRunning <= oscCnt >= OSC_START;
		end
	end

	// One instruction every two or five clocks while clocked
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n || !cpuClockEnable) begin
			instCnt   <= 0;
			instrDone <= 1'b0;
		end else begin
			instrDone <= instCnt == lastCnt;
			instCnt   <= (instCnt == lastCnt) ? 0 : instCnt + 1;
		end
	end
endmodule

// ### tb/srs_seq_monitor.sv
/*
 Port checker for the standby release and reset sequencer.
 Assumes one clock and an active-low asynchronous reset; bound below.
*/
`timescale 1ns/1ps
module srs_seq_monitor
	import srs_pkg::*;
#(
	parameter int NUM_IRQ = 8
) (
	// Clock and reset
	input wire logic               clock,
	input wire logic               arst_n,
	// APB
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [11:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	// Pins and interrupts
	input wire logic               resetPin_n,
	input wire logic               oscRunning,
	input wire logic               oscEnable,
	input wire logic [NUM_IRQ-1:0] irqReq,
	input wire logic [NUM_IRQ-1:0] irqEn,
	// CPU side
	input wire logic [7:0]         romByte0,
	input wire logic [7:0]         romByte1,
	input wire logic               instrDone,
	input wire logic               cpuClockEnable,
	input wire logic               resumeNext,
	input wire logic               takeVector,
	input wire logic               pcLoad,
	input wire logic [13:0]        program_counter,
	input wire logic               reg_bank_enable,
	input wire logic               mem_bank_enable,
	input wire logic [NUM_IRQ-1:0] wakeCause,
	// Reset-cleared state
	input wire logic [3:0]         interval_timer_mode,
	input wire logic [7:0]         watch_timer_mode,
	input wire logic [3:0]         mem_bank_select,
	input wire logic [1:0]         reg_bank_select,
	input wire logic [1:0]         nestStatus,
	input wire logic [2:0]         skipFlags
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Standby request from run with nothing pending to wake it
	logic calmPcc;
	assign calmPcc = psel && penable && pready && pwrite
		&& paddr == SRS_OFS_PCC && cpuClockEnable && resetPin_n
		&& !(|(irqReq & irqEn));

	chk_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_stop_osc_off: assert property (
		calmPcc && pwdata[3] |-> ##[1:2] !oscEnable)
		else $error("stop did not halt the oscillator");
	chk_halt_gates_cpu: assert property (
		calmPcc && pwdata[2] && !pwdata[3] |=> !cpuClockEnable)
		else $error("halt did not gate the cpu clock");
	chk_clock_after_osc: assert property (
		$rose(cpuClockEnable) |-> oscRunning)
		else $error("cpu clock before oscillator running");
	chk_reset_no_resume: assert property (
		pcLoad |-> !resumeNext && !takeVector)
		else $error("reset completion resumed program");
	chk_vector_after_instr: assert property (
		takeVector |-> $past(instrDone) && !$past(takeVector))
		else $error("vector not right after an instruction");
	chk_vector_cause_ok: assert property (
		takeVector |-> |(wakeCause >> 2))
		else $error("vector taken for watch or ext2 wake");
	chk_pc_from_rom: assert property (
		pcLoad |-> program_counter == {romByte0[5:0], romByte1})
		else $error("program counter load wrong");
	chk_bank_enables: assert property (
		pcLoad |-> reg_bank_enable == romByte0[6]
		&& mem_bank_enable == romByte0[7])
		else $error("bank enable load wrong");
	chk_psw_bank_clear: assert property (
		!resetPin_n [*7] |-> nestStatus == 2'h0 && skipFlags == 3'h0
		&& mem_bank_select == 4'h0 && reg_bank_select == 2'h0)
		else $error("psw or bank select not cleared");
	chk_timer_mode_clear: assert property (
		!resetPin_n [*7] |-> watch_timer_mode == 8'h00
		&& interval_timer_mode == 4'h0)
		else $error("timer modes not cleared");

	// Main scenarios reached
	cov_vector: cover property (takeVector);
	cov_resume: cover property (resumeNext && oscEnable);
	cov_pc_load: cover property (pcLoad);
endmodule

bind srs_standby_seq srs_seq_monitor #(.NUM_IRQ(NUM_IRQ)) u_mon (
	.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.resetPin_n, .oscRunning, .oscEnable, .irqReq, .irqEn, .romByte0,
	.romByte1, .instrDone, .cpuClockEnable, .resumeNext, .takeVector,
	.pcLoad, .program_counter, .reg_bank_enable, .mem_bank_enable,
	.wakeCause, .interval_timer_mode, .watch_timer_mode,
	.mem_bank_select, .reg_bank_select, .nestStatus, .skipFlags);

// ### tb/srs_standby_seq_tb.sv
/*
 Self-checking bench for the standby sequencer with short waits.
 Assumes the bound checker and the far-side model beside the DUT.
*/
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module srs_standby_seq_tb
	import srs_pkg::*;
;
	localparam int RW = 100;
	logic clock = 1'b0;
	logic arst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic resetPin_n, oscRunning, oscEnable, global_irq_enable, slow;
	logic [7:0] irqReq, irqEn, romByte0, romByte1, wakeCause;
	logic instrDone, cpuClockEnable, resumeNext, takeVector, pcLoad;
	logic [13:0] program_counter;
	logic reg_bank_enable, mem_bank_enable, regsRetained;
	logic [3:0] interval_timer_mode, mem_bank_select;
	logic [7:0] watch_timer_mode;
	logic [1:0] reg_bank_select, nestStatus;
	logic [2:0] skipFlags;
	int mismatches = 0;
	int comparisons = 0;
	int n;

	srs_standby_seq #(.WAIT_A_CYC(64), .WAIT_B_CYC(32), .WAIT_C_CYC(16),
		.WAIT_D_CYC(8), .RESET_WAIT(RW)) DUT (.clock, .arst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.resetPin_n, .oscRunning, .oscEnable, .irqReq, .irqEn,
		.global_irq_enable, .romByte0, .romByte1, .instrDone,
		.cpuClockEnable, .resumeNext, .takeVector, .pcLoad,
		.program_counter, .reg_bank_enable, .mem_bank_enable,
		.regsRetained, .wakeCause, .interval_timer_mode,
		.watch_timer_mode, .mem_bank_select, .reg_bank_select,
		.nestStatus, .skipFlags);
	srs_cpu_model u_cpu (.clock, .arst_n, .oscEnable, .cpuClockEnable,
		.slow, .oscRunning, .instrDone, .romByte0, .romByte1);

	// 40 MHz
	always #12.5 clock = ~clock;

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic er);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	task automatic regWr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, d, r, er);
	endtask

	task automatic regChk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		logic er;
		apb(1'b0, a, 32'h0, r, er);
		`CHK(r, e);
	endtask

	// Bounded wait; the count returned equals lim if it never came
	task automatic waitHi(ref logic s, input int lim, output int k);
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (s !== 1'b1 && k < lim);
	endtask

	task automatic irqSet(input logic [7:0] r, input logic [7:0] e);
		@(posedge clock);
		irqReq <= r;
		irqEn <= e;
	endtask

	task automatic t_boot;
		waitHi(pcLoad, RW + 40, n);
		`CHK(n >= RW && n <= RW + 20, 1);
		`CHK(program_counter, 14'h353c);
		`CHK({mem_bank_enable, reg_bank_enable}, 2'b10);
		$display("test boot done");
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic er;
		regChk(SRS_OFS_ITM, 32'h0);
		regChk(SRS_OFS_WTM, 32'h0);
		regChk(SRS_OFS_BANK, 32'h0);
		regChk(SRS_OFS_PSW, 32'h0);
		apb(1'b0, 12'h018, 32'h0, r, er);
		`CHK({er, r[30:0]}, 32'h8000_0000);
		$display("test regs done");
	endtask

	task automatic t_halt;
		regWr(SRS_OFS_PCC, 32'h4);
		irqSet(8'h08, 8'h00);
		repeat (6) @(negedge clock);
		`CHK(cpuClockEnable, 0);
		irqSet(8'h08, 8'h08);
		waitHi(resumeNext, 10, n);
		`CHK(n <= 3, 1);
		`CHK(wakeCause, 8'h08);
		waitHi(takeVector, 20, n);
		`CHK(n, 20);
		irqSet(8'h00, 8'h00);
		$display("test halt done");
	endtask

	task automatic t_vector;
		int b [3] = '{4, 0, 1};
		global_irq_enable <= 1'b1;
		foreach (b[i]) begin
			slow <= b[i] == 4;
			regWr(SRS_OFS_PCC, 32'h4);
			irqSet(8'h1 << b[i], 8'h1 << b[i]);
			waitHi(resumeNext, 10, n);
			irqSet(8'h00, 8'h00);
			waitHi(takeVector, 30, n);
			`CHK(n < 30, b[i] == 4);
		end
		global_irq_enable <= 1'b0;
		$display("test vector done");
	endtask

	task automatic t_stop;
		logic [3:0] code [4] = '{4'h0, 4'hb, 4'h5, 4'hf};
		int w [4] = '{64, 32, 16, 8};
		foreach (w[i]) begin
			regWr(SRS_OFS_ITM, 32'(code[i]));
			regWr(SRS_OFS_PCC, 32'h8);
			repeat (3) @(negedge clock);
			`CHK(oscEnable, 0);
			irqSet(8'h04, 8'h04);
			waitHi(oscRunning, 60, n);
			waitHi(resumeNext, 200, n);
			`CHK(n >= w[i] && n <= w[i] + 8, 1);
			irqSet(8'h00, 8'h00);
		end
		$display("test stop done");
	endtask

	task automatic t_pending;
		logic oscLow;
		regWr(SRS_OFS_ITM, 32'h7);
		irqSet(8'h20, 8'h20);
		regWr(SRS_OFS_PCC, 32'h8);
		n = 0;
		oscLow = 1'b0;
		do begin
			@(negedge clock);
			n++;
			oscLow |= oscEnable !== 1'b1;
		end while (resumeNext !== 1'b1 && n < 60);
		`CHK({oscLow, n >= 6 && n <= 30}, 2'b01);
		irqSet(8'h00, 8'h00);
		$display("test pending done");
	endtask

	task automatic t_reset;
		regWr(SRS_OFS_WTM, 32'ha5);
		regWr(SRS_OFS_BANK, 32'h35);
		regWr(SRS_OFS_PSW, 32'h1f);
		regWr(SRS_OFS_PCC, 32'h4);
		for (int i = 1; i >= 0; i--) begin
			@(posedge clock);
			resetPin_n <= 1'b0;
			repeat (8) @(posedge clock);
			regChk(SRS_OFS_WTM, 32'h0);
			regChk(SRS_OFS_BANK, 32'h0);
			regChk(SRS_OFS_PSW, 32'h0);
			resetPin_n <= 1'b1;
			waitHi(pcLoad, RW + 40, n);
			`CHK({n < RW + 40, regsRetained}, {1'b1, i[0]});
		end
		$display("test reset done");
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{irqReq, irqEn, global_irq_enable, slow} = '0;
		resetPin_n = 1'b1;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		t_boot;
		t_regs;
		t_halt;
		t_vector;
		t_stop;
		t_pending;
		t_reset;
		tally_and_finish;
	end

	// Whole run needs about 800 cycles
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		$display("watchdog expired");
		tally_and_finish;
	end
endmodule
